// File: rtl/dcf_fifo.sv
/*
  Dual-clock 9-bit buffer with empty, full and programmable almost
  flags, offset registers and an AHB-Lite status/control slave.
  Assumes write and read clocks arrive as pins far slower than mclk_i.
*/
// Design decisions made here: the placing of the registers and register access over AHB-Lite.
// How it works
// RQ1 - separate 9-bit write and read buses
// RQ2 - 16K-word array, independent read/write pointers
// RQ3 - strap high: pin becomes second write enable
// RQ4 - strap low: pin becomes offset load control
// RQ5 - load mode: store on first enable, not full
// RQ6 - two-enable mode: both enables and not full
// RQ7 - writes ignored while full
// RQ8 - pop only with both enables, not empty
// RQ9 - reader drives both read enables together
// RQ10 - load low: write goes to offset register
// RQ11 - load low: read returns offset register
// RQ12 - full flag low when full, write side
// RQ13 - empty flags move only on read edges
// RQ14 - full flags move only on write edges
// RQ15 - almost empty low at programmed level
// RQ16 - almost full low at programmed space
// RQ17 - thresholds default to seven words
// RQ18 - thresholds settable per single word
// RQ19 - flag holds at least one cycle
// RQ20 - reset before first access after power-up
// RQ21 - reset empties buffer, clears outputs
// RQ22 - no access while reset is low
// RQ23 - flags valid while reset held low
// RQ24 - output enable low drives data outputs
// RQ25 - offset writes cycle through four registers
// RQ26 - offsets never read and written together
// RQ27 - almost empty high at n+1 words
// RQ28 - empty buffer keeps last read word
// RQ29 - pointers cross as gray code
// RQ30 - selector and offsets reset to defaults
`default_nettype none
`include "dcf_defs.svh"
module dcf_fifo
  import dcf_pkg::*;
(
  input  wire logic                   mclk_i,
  input  wire logic                   resetn_i,
  input  wire logic                   write_clk_i,
  input  wire logic                   read_clk_i,
  input  wire logic [`DCF_DW-1:0]     write_data_i,
  input  wire logic                   write_enable_first_n_i,
  input  wire logic                   write_enable_second_or_load_i,
  input  wire logic                   read_enable_first_n_i,
  input  wire logic                   read_enable_second_n_i,
  input  wire logic                   output_enable_n_i,
  output logic      [`DCF_DW-1:0]     read_data_o,
  output logic                        read_data_oe_o,
  output logic                        empty_flag_n_o,
  output logic                        full_flag_n_o,
  output logic                        almost_empty_flag_n_o,
  output logic                        almost_full_flag_n_o,
  input  wire logic                   hsel_i,
  input  wire logic [31:0]            haddr_i,
  input  wire logic [1:0]             htrans_i,
  input  wire logic                   hwrite_i,
  input  wire logic [2:0]             hsize_i,
  input  wire logic [31:0]            hwdata_i,
  input  wire logic                   hready_i,
  output logic      [31:0]            hrdata_o,
  output logic                        hreadyout_o,
  output logic                        hresp_o
);
  // ******************************************************
  // helpers
  // ******************************************************
  function automatic dcf_sel_t sel_next(input dcf_sel_t s);
    case (s)
      SEL_EMPTY_LO: sel_next = SEL_EMPTY_HI;
      SEL_EMPTY_HI: sel_next = SEL_FULL_LO;
      SEL_FULL_LO:  sel_next = SEL_FULL_HI;
      default:      sel_next = SEL_EMPTY_LO;
    endcase
  endfunction

  function automatic logic [`DCF_PW-1:0] fill(input logic [`DCF_PW-1:0] w,
                                              input logic [`DCF_PW-1:0] r);
    fill = w - r;
  endfunction

  // ******************************************************
  // pin synchronisers
  // ******************************************************
  localparam int PW_N = `DCF_DW + 6;
  logic [1:0]      clk_sync;
  logic [1:0]      clk_rise;
  logic [PW_N-1:0] pin_sync;
  logic [`DCF_DW-1:0] wdata;
  logic            write_enable_first_n_n;
  logic            write_enable_second_or_load;
  logic            read_enable_first_n_n;
  logic            read_enable_second_n_n;
  logic            oe_n;
  logic            w_rise;
  logic            r_rise;

  dcf_pin_sync #(.W(2)) u_clk_sync (
    .mclk_i (mclk_i),
    .pin_i  ({read_clk_i, write_clk_i}),
    .sync_o (clk_sync),
    .rise_o (clk_rise)
  );

  dcf_pin_sync #(.W(PW_N)) u_pin_sync (
    .mclk_i (mclk_i),
    .pin_i  ({output_enable_n_i, read_enable_second_n_i, read_enable_first_n_i,
              write_enable_second_or_load_i, write_enable_first_n_i, 1'b0, write_data_i}),
    .sync_o (pin_sync),
    .rise_o ()
  );

  assign w_rise  = clk_rise[0];
  assign r_rise  = clk_rise[1];
  assign wdata   = pin_sync[`DCF_DW-1:0];
  assign write_enable_first_n_n  = pin_sync[`DCF_DW+1];
  assign write_enable_second_or_load = pin_sync[`DCF_DW+2];
  assign read_enable_first_n_n  = pin_sync[`DCF_DW+3];
  assign read_enable_second_n_n  = pin_sync[`DCF_DW+4];
  assign oe_n    = pin_sync[`DCF_DW+5];

  // ******************************************************
  // mode strap
  // ******************************************************
  logic run_q;
  logic two_en_q;

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      run_q <= 1'b0;
    end else begin
      run_q <= 1'b1;
    end
  end

  // tracks the pin while reset is low and on the first edge after release, frozen from the second edge
  always_ff @(posedge mclk_i) begin
    if (!run_q) begin
      two_en_q <= write_enable_second_or_load; // RQ3 RQ4
    end
  end

  // ******************************************************
  // bus slave
  // ******************************************************
  logic                  ctrl_en_q;
  logic                  ap_wr_q;
  logic [`DCF_ADDR_W-1:0] ap_addr_q;
  logic [31:0]           status;
  logic                  ap_take;

  assign ap_take = hsel_i & hready_i & htrans_i[1];

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ap_wr_q   <= 1'b0;
      ap_addr_q <= '0;
    end else if (hready_i) begin
      ap_wr_q   <= ap_take & hwrite_i;
      ap_addr_q <= haddr_i[`DCF_ADDR_W-1:0];
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl_en_q <= `DCF_CTRL_RST;
    end else if (ap_wr_q && ap_addr_q == `DCF_CTRL_ADDR) begin
      ctrl_en_q <= hwdata_i[`DCF_CTRL_EN_BIT];
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      hrdata_o    <= '0;
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end else if (ap_take && !hwrite_i) begin
      if (haddr_i[`DCF_ADDR_W-1:0] == `DCF_CTRL_ADDR) begin
        hrdata_o <= 32'(ctrl_en_q);
      end else if (haddr_i[`DCF_ADDR_W-1:0] == `DCF_STAT_ADDR) begin
        hrdata_o <= status;
      end else begin
        hrdata_o <= '0;
      end
    end
  end

  // ******************************************************
  // pointers and storage
  // ******************************************************
  logic [`DCF_DW-1:0] mem_q [0:`DCF_DEPTH-1]; // RQ2
  logic [`DCF_PW-1:0] wptr_q;
  logic [`DCF_PW-1:0] rptr_q;
  logic [`DCF_PW-1:0] wptr_rd;
  logic [`DCF_PW-1:0] rptr_wr;
  logic [`DCF_PW-1:0] wptr_d;
  logic [`DCF_PW-1:0] rptr_d;
  logic [`DCF_DW-1:0] read_data_q;
  logic               full_n_q;
  logic               afull_n_q;
  logic               empty_n_q;
  logic               aempty_n_q;
  logic               oe_q;
  logic               load_low;
  logic               wr_fire;
  logic               rd_fire;
  logic               ofs_wr;
  logic               ofs_rd;

  // load mode with the pin low steers accesses to the offsets
  assign load_low = !two_en_q && !write_enable_second_or_load;
  // same gate for both modes: in load mode a buffer write needs the pin high
  assign wr_fire  = run_q && ctrl_en_q && w_rise && !write_enable_first_n_n && write_enable_second_or_load && full_n_q; // RQ5 RQ6 RQ7
  assign rd_fire  = run_q && ctrl_en_q && r_rise && !read_enable_first_n_n && !read_enable_second_n_n && empty_n_q && !load_low; // RQ8 RQ9
  assign ofs_wr   = run_q && ctrl_en_q && w_rise && load_low && !write_enable_first_n_n; // RQ10
  assign ofs_rd   = run_q && ctrl_en_q && r_rise && load_low && !read_enable_first_n_n && !read_enable_second_n_n; // RQ11
  assign wptr_d   = wr_fire ? wptr_q + 1'b1 : wptr_q;
  assign rptr_d   = rd_fire ? rptr_q + 1'b1 : rptr_q;

  always_ff @(posedge mclk_i) begin
    if (wr_fire) begin
      mem_q[wptr_q[`DCF_AW-1:0]] <= wdata; // RQ1
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wptr_q <= '0; // RQ21
      rptr_q <= '0;
    end else begin
      wptr_q <= wptr_d;
      rptr_q <= rptr_d;
    end
  end

  dcf_ptr_cross u_w2r (
    .mclk_i   (mclk_i),
    .resetn_i (resetn_i),
    .bin_i    (wptr_q),
    .bin_o    (wptr_rd)
  ); // RQ29

  dcf_ptr_cross u_r2w (
    .mclk_i   (mclk_i),
    .resetn_i (resetn_i),
    .bin_i    (rptr_q),
    .bin_o    (rptr_wr)
  ); // RQ29

  // ******************************************************
  // offset registers
  // ******************************************************
  dcf_sel_t          sel_q;
  logic [7:0]        elo_q;
  logic [7:0]        ehi_q;
  logic [7:0]        flo_q;
  logic [7:0]        fhi_q;
  logic [7:0]        ofs_pick;
  logic [`DCF_OFS_W-1:0] n_ofs;
  logic [`DCF_OFS_W-1:0] m_ofs;

  assign n_ofs = {ehi_q[`DCF_OFS_HI_W-1:0], elo_q}; // RQ18
  assign m_ofs = {fhi_q[`DCF_OFS_HI_W-1:0], flo_q};

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sel_q <= SEL_EMPTY_LO; // RQ30
    end else if (ofs_wr || ofs_rd) begin
      sel_q <= sel_next(sel_q); // RQ25
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      elo_q <= `DCF_OFS_LO_DEF; // RQ17 RQ30
      ehi_q <= `DCF_OFS_HI_DEF;
      flo_q <= `DCF_OFS_LO_DEF;
      fhi_q <= `DCF_OFS_HI_DEF;
    end else if (ofs_wr) begin
      case (sel_q)
        SEL_EMPTY_LO: elo_q <= wdata[7:0];
        SEL_EMPTY_HI: ehi_q <= wdata[7:0];
        SEL_FULL_LO:  flo_q <= wdata[7:0];
        default:      fhi_q <= wdata[7:0];
      endcase
    end
  end

  always_comb begin
    case (sel_q)
      SEL_EMPTY_LO: ofs_pick = elo_q;
      SEL_EMPTY_HI: ofs_pick = ehi_q;
      SEL_FULL_LO:  ofs_pick = flo_q;
      default:      ofs_pick = fhi_q;
    endcase
  end

  // ******************************************************
  // read data and output enable
  // ******************************************************
  // an empty buffer blocks rd_fire, so the last word stays put
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      read_data_q <= '0; // RQ21
      oe_q        <= 1'b0;
    end else begin
      oe_q <= !oe_n; // RQ24
      if (rd_fire) begin
        read_data_q <= mem_q[rptr_q[`DCF_AW-1:0]]; // RQ28
      end else if (ofs_rd) begin
        read_data_q <= {1'b0, ofs_pick}; // RQ11
      end
    end
  end

  // ******************************************************
  // flags
  // ******************************************************
  logic [`DCF_PW-1:0] lvl_w;
  logic [`DCF_PW-1:0] lvl_r;

  assign lvl_w = fill(wptr_d, rptr_wr);
  assign lvl_r = fill(wptr_rd, rptr_d);

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      full_n_q  <= 1'b1; // RQ23
      afull_n_q <= 1'b1;
    end else if (w_rise) begin
      full_n_q  <= lvl_w != `DCF_DEPTH; // RQ12 RQ14
      afull_n_q <= lvl_w < `DCF_DEPTH - {1'b0, m_ofs}; // RQ16
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      empty_n_q  <= 1'b0; // RQ21 RQ23
      aempty_n_q <= 1'b0;
    end else if (r_rise) begin
      empty_n_q  <= lvl_r != '0; // RQ13
      aempty_n_q <= lvl_r > {1'b0, n_ofs}; // RQ15 RQ27
    end
  end

  always_comb begin
    status = '0;
    status[`DCF_ST_FULL]   = full_n_q;
    status[`DCF_ST_AFULL]  = afull_n_q;
    status[`DCF_ST_EMPTY]  = empty_n_q;
    status[`DCF_ST_AEMPTY] = aempty_n_q;
    status[`DCF_ST_TWO_EN] = two_en_q;
    status[`DCF_ST_LVL_MSB:`DCF_ST_LVL_LSB] = fill(wptr_q, rptr_wr);
  end

  assign read_data_o           = read_data_q;
  assign read_data_oe_o        = oe_q;
  assign full_flag_n_o         = full_n_q;
  assign almost_full_flag_n_o  = afull_n_q;
  assign empty_flag_n_o        = empty_n_q;
  assign almost_empty_flag_n_o = aempty_n_q;

  // ******************************************************
  // assertions
  // ******************************************************
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);

  sequence s_wr_try_full;
    w_rise && !full_n_q;
  endsequence
  sequence s_rd_try_empty;
    r_rise && !empty_n_q && !load_low;
  endsequence

  property p_no_write_full;
    s_wr_try_full |=> wptr_q == $past(wptr_q);
  endproperty
  a_no_write_full: assert property (p_no_write_full) else $error("write while full"); // RQ7

  property p_no_read_empty;
    s_rd_try_empty |=> rptr_q == $past(rptr_q) && $stable(read_data_q);
  endproperty
  a_no_read_empty: assert property (p_no_read_empty) else $error("read while empty"); // RQ8 RQ28

  property p_empty_read_side;
    !r_rise |=> $stable(empty_n_q) && $stable(aempty_n_q);
  endproperty
  a_empty_read_side: assert property (p_empty_read_side) else $error("empty flag off read edge"); // RQ13

  property p_full_write_side;
    !w_rise |=> $stable(full_n_q) && $stable(afull_n_q);
  endproperty
  a_full_write_side: assert property (p_full_write_side) else $error("full flag off write edge"); // RQ14

  property p_full_low;
    w_rise && lvl_w == `DCF_DEPTH |=> !full_n_q ##1 !full_n_q;
  endproperty
  a_full_low: assert property (p_full_low) else $error("full flag not low"); // RQ12 RQ19

  property p_sel_wrap;
    ofs_wr && sel_q == SEL_FULL_HI |=> sel_q == SEL_EMPTY_LO;
  endproperty
  a_sel_wrap: assert property (p_sel_wrap) else $error("selector did not wrap"); // RQ25

  property p_two_en_gate;
    two_en_q && w_rise && !write_enable_second_or_load |=> wptr_q == $past(wptr_q) && $stable(sel_q);
  endproperty
  a_two_en_gate: assert property (p_two_en_gate) else $error("write without second enable"); // RQ6

  property p_flag_hold;
    $changed(empty_n_q) |=> $stable(empty_n_q);
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag held under one cycle"); // RQ19

  property p_aempty;
    r_rise && lvl_r > {1'b0, n_ofs} |=> aempty_n_q && empty_n_q;
  endproperty
  a_aempty: assert property (p_aempty) else $error("almost empty not high"); // RQ27

  property p_ofs_load;
    ofs_wr && sel_q == SEL_EMPTY_LO |=> elo_q == $past(wdata[7:0]);
  endproperty
  a_ofs_load: assert property (p_ofs_load) else $error("offset not loaded"); // RQ10
endmodule
`default_nettype wire

// File: include/dcf_defs.svh
/*
  Constants of the dual-clock 9-bit buffer: sizes, reset values,
  register offsets and status field positions.
  Assumes inclusion by bare name from the package and the design files.
*/
`ifndef DCF_DEFS_SVH
`define DCF_DEFS_SVH

`define DCF_DW          9
`define DCF_AW          14
`define DCF_PW          15
`define DCF_DEPTH       15'h4000
`define DCF_OFS_LO_DEF  8'h07
`define DCF_OFS_HI_DEF  8'h00
`define DCF_OFS_HI_W    6
`define DCF_OFS_W       14
`define DCF_SYNC_STAGES 2

// register map, byte addresses on the bus
`define DCF_ADDR_W      8
`define DCF_CTRL_ADDR   8'h00
`define DCF_STAT_ADDR   8'h04
`define DCF_CTRL_EN_BIT 0
`define DCF_CTRL_RST    1'b1

// status field positions
`define DCF_ST_FULL     0
`define DCF_ST_AFULL    1
`define DCF_ST_EMPTY    2
`define DCF_ST_AEMPTY   3
`define DCF_ST_TWO_EN   4
`define DCF_ST_LVL_LSB  16
`define DCF_ST_LVL_MSB  30

`endif

// File: include/dcf_pkg.sv
/*
  Types of the dual-clock 9-bit buffer.
  Assumes dcf_defs.svh on the include path.
*/
`default_nettype none
`include "dcf_defs.svh"
package dcf_pkg;
  typedef enum logic [3:0] {
    SEL_EMPTY_LO = 4'b0001,
    SEL_EMPTY_HI = 4'b0010,
    SEL_FULL_LO  = 4'b0100,
    SEL_FULL_HI  = 4'b1000
  } dcf_sel_t;
endpackage
`default_nettype wire

// File: rtl/dcf_pin_sync.sv
/*
  Two-flop synchroniser for a group of pins, with rising-edge pulses
  taken after the second stage.
  Assumes pins are asynchronous to mclk_i and change slower than it.
*/
`default_nettype none
module dcf_pin_sync
  import dcf_pkg::*;
#(
  parameter int W = 1
) (
  input  wire logic         mclk_i,
  input  wire logic [W-1:0] pin_i,
  output logic      [W-1:0] sync_o,
  output logic      [W-1:0] rise_o
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  logic [W-1:0] last_q;

  // no reset: the straps must be seen while reset is still low
  always_ff @(posedge mclk_i) begin
    meta_q <= pin_i;
    sync_q <= meta_q;
    last_q <= sync_q;
  end

  assign sync_o = sync_q;
  assign rise_o = sync_q & ~last_q;
endmodule
`default_nettype wire

// File: rtl/dcf_ptr_cross.sv
/*
  Pointer crossing between the write and read sides: gray coded at the
  source, two flops, converted back to binary.
  Assumes the source pointer moves by at most one per source edge.
*/
`default_nettype none
`include "dcf_defs.svh"
module dcf_ptr_cross
  import dcf_pkg::*;
(
  input  wire logic                mclk_i,
  input  wire logic                resetn_i,
  input  wire logic [`DCF_PW-1:0]  bin_i,
  output logic      [`DCF_PW-1:0]  bin_o
);
  logic [`DCF_PW-1:0] gray_q;
  logic [`DCF_PW-1:0] meta_q;
  logic [`DCF_PW-1:0] sync_q;

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      gray_q <= '0;
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      gray_q <= bin_i ^ (bin_i >> 1);
      meta_q <= gray_q;
      sync_q <= meta_q;
    end
  end

  always_comb begin
    bin_o[`DCF_PW-1] = sync_q[`DCF_PW-1];
    for (int i = `DCF_PW - 2; i >= 0; i--) begin
      bin_o[i] = bin_o[i+1] ^ sync_q[i];
    end
  end
endmodule
`default_nettype wire

// File: tb/dcf_far_model.sv
/*
  Far-side writer and reader of the buffer: pin clocks, data, enables.
  Assumes mclk_i is the design clock and one task runs at a time.
*/
`default_nettype none
`include "dcf_defs.svh"
module dcf_far_model
  import dcf_pkg::*;
(
  input  wire logic              mclk_i,
  output logic                   write_clk_o,
  output logic                   read_clk_o,
  output logic [`DCF_DW-1:0]     write_data_o,
  output logic                   write_enable_first_n_o,
  output logic                   write_enable_second_or_load_o,
  output logic                   read_enable_first_n_o,
  output logic                   read_enable_second_n_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************
  // pin traffic
  // ****************************************
  // clocks stand low between frames; 4 mclk per phase covers the 3-cycle sync margin
  initial begin
    write_clk_o = 1'b0;
    read_clk_o = 1'b0;
    write_data_o = '0;
    write_enable_first_n_o = 1'b1;
    write_enable_second_or_load_o = 1'b0;
    read_enable_first_n_o = 1'b1;
    read_enable_second_n_o = 1'b1;
  end

  task automatic strap(input logic v);
    @(posedge mclk_i);
    write_enable_second_or_load_o <= v;
  endtask

  // tasks never overlap, so offset reads and writes are never simultaneous
  task automatic wr(input logic [`DCF_DW-1:0] d, input logic e1, input logic e2);
    @(posedge mclk_i);
    write_data_o <= d;
    write_enable_first_n_o <= e1;
    write_enable_second_or_load_o <= e2;
    repeat (4) @(posedge mclk_i);
    write_clk_o <= 1'b1;
    repeat (4) @(posedge mclk_i);
    write_clk_o <= 1'b0;
    write_data_o <= ~d;
    write_enable_first_n_o <= 1'b1;
    repeat (4) @(posedge mclk_i);
  endtask

  // split enables only when the bench asks for them
  task automatic rd(input logic e1, input logic e2);
    @(posedge mclk_i);
    read_enable_first_n_o <= e1;
    read_enable_second_n_o <= e2;
    repeat (4) @(posedge mclk_i);
    read_clk_o <= 1'b1;
    repeat (4) @(posedge mclk_i);
    read_clk_o <= 1'b0;
    read_enable_first_n_o <= 1'b1;
    read_enable_second_n_o <= 1'b1;
    repeat (4) @(posedge mclk_i);
  endtask
endmodule
`default_nettype wire

// File: tb/tb.sv
/*
  Self-checking bench of the dual-clock buffer: pin traffic via the far-side
  model, registers over AHB-Lite, flags and read data compared from a queue.
  Assumes the design files and dcf_far_model are compiled first.
*/
`default_nettype none
`include "dcf_defs.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic             mclk_i;
  logic             resetn_i;
  logic             wclk;
  logic             rclk;
  logic [8:0]       wdata;
  logic             write_enable_first_n_n;
  logic             wen2;
  logic             read_enable_first_n_n;
  logic             read_enable_second_n_n;
  logic             oe_n;
  logic [8:0]       rdata;
  logic             rdata_oe;
  logic [3:0]       flags;
  logic             hsel;
  logic [31:0]      haddr;
  logic [1:0]       htrans;
  logic             hwrite;
  logic [2:0]       hsize;
  logic [31:0]      hwdata;
  logic [31:0]      hrdata;
  logic             hready;
  logic             hresp;
  logic [31:0]      v;
  logic [8:0]       d [3];
  logic [8:0]       dflt [4] = '{9'h007, 9'h000, 9'h007, 9'h000};
  logic [8:0]       prog [4] = '{9'h002, 9'h000, 9'h0FE, 9'h03F};
  logic [31:0]      exp_q [$];
  logic [31:0]      seen_q [$];
  int               miscompares = 0;
  int               compares = 0;
  integer           seed;
  event             got;

  dcf_fifo uut (
    .mclk_i(mclk_i), .resetn_i(resetn_i), .write_clk_i(wclk), .read_clk_i(rclk),
    .write_data_i(wdata), .write_enable_first_n_i(write_enable_first_n_n), .write_enable_second_or_load_i(wen2),
    .read_enable_first_n_i(read_enable_first_n_n), .read_enable_second_n_i(read_enable_second_n_n), .output_enable_n_i(oe_n),
    .read_data_o(rdata), .read_data_oe_o(rdata_oe), .empty_flag_n_o(flags[3]),
    .almost_empty_flag_n_o(flags[2]), .full_flag_n_o(flags[1]), .almost_full_flag_n_o(flags[0]),
    .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize),
    .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp)
  );

  dcf_far_model u_far (
    .mclk_i(mclk_i), .write_clk_o(wclk), .read_clk_o(rclk), .write_data_o(wdata),
    .write_enable_first_n_o(write_enable_first_n_n), .write_enable_second_or_load_o(wen2),
    .read_enable_first_n_o(read_enable_first_n_n), .read_enable_second_n_o(read_enable_second_n_n)
  );

  initial begin
    mclk_i = 1'b0;
    forever #10 mclk_i = ~mclk_i;
  end

  // ****************************************
  // checking and verdict
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    seen_q.push_back(seen);
    exp_q.push_back(exp);
    ->got;
  endtask

  task automatic results;
    if (miscompares == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    forever begin
      @(got);
      while (exp_q.size() > 0) begin
        check(seen_q.pop_front(), exp_q.pop_front());
      end
    end
  end

  initial begin
    repeat (20000) @(posedge mclk_i);
    miscompares++;
    results();
  end

  // ****************************************
  // bus and reset helpers
  // ****************************************
  task automatic wait_rdy;
    int n;
    n = 0;
    @(posedge mclk_i);
    while (hready !== 1'b1 && n < 16) begin
      @(posedge mclk_i);
      n++;
    end
    if (hready !== 1'b1) begin
      miscompares++;
      results();
    end
  endtask

  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    @(posedge mclk_i);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    v = hrdata;
    chk(32'(hresp), 32'h0);
  endtask

  // no pin access while reset is low; strap settles well before release
  task automatic reset_dut(input logic s);
    @(posedge mclk_i);
    resetn_i <= 1'b0;
    u_far.strap(s);
    repeat (8) @(posedge mclk_i);
    chk(32'(flags), 32'h3);
    repeat (10) @(posedge mclk_i);
    resetn_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    chk(32'(rdata), 32'h0);
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    seed = 32057;
    resetn_i = 1'b0;
    oe_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    reset_dut(1'b0);
    ahb(1'b0, 32'h0, 32'h0);
    chk(v, 32'h1);
    ahb(1'b0, 32'h4, 32'h0);
    chk(v, 32'h3);
    ahb(1'b0, 32'h8, 32'h0);
    chk(v, 32'h0);
    for (int i = 0; i < 4; i++) begin
      u_far.rd(1'b0, 1'b0);
      chk(32'(rdata), 32'(dflt[i]));
    end
    // n = 2, m = 16382: almost full from two words
    for (int i = 0; i < 4; i++) begin
      u_far.wr(prog[i], 1'b0, 1'b0);
    end
    for (int i = 0; i < 4; i++) begin
      u_far.rd(1'b0, 1'b0);
      chk(32'(rdata), 32'(prog[i]));
    end
    for (int i = 0; i < 3; i++) begin
      d[i] = 9'($random(seed));
    end
    u_far.wr(9'h1AA, 1'b1, 1'b1);
    u_far.wr(d[0], 1'b0, 1'b1);
    chk(32'(flags), 32'h3);
    u_far.wr(d[1], 1'b0, 1'b1);
    chk(32'(flags), 32'h2);
    u_far.rd(1'b1, 1'b1);
    chk(32'(flags), 32'hA);
    u_far.wr(d[2], 1'b0, 1'b1);
    u_far.rd(1'b1, 1'b0);
    chk(32'(flags), 32'hE);
    chk(32'(rdata), 32'h3F);
    u_far.rd(1'b0, 1'b1);
    chk(32'(rdata), 32'h3F);
    for (int i = 0; i < 4; i++) begin
      u_far.rd(1'b0, 1'b0);
      chk(32'(rdata), 32'(d[i > 2 ? 2 : i]));
    end
    chk(32'(flags), 32'h2);
    u_far.wr(9'h000, 1'b1, 1'b1);
    chk(32'(flags), 32'h3);
    // disabled block must drop pin writes
    ahb(1'b1, 32'h0, 32'h0);
    u_far.wr(9'h155, 1'b0, 1'b1);
    ahb(1'b0, 32'h4, 32'h0);
    chk(v, 32'h3);
    ahb(1'b1, 32'h0, 32'h1);
    // two sync flops plus the output register: settled one edge after it loads
    oe_n <= 1'b1;
    repeat (4) @(posedge mclk_i);
    chk(32'(rdata_oe), 32'h0);
    oe_n <= 1'b0;
    repeat (4) @(posedge mclk_i);
    chk(32'(rdata_oe), 32'h1);
    reset_dut(1'b1);
    ahb(1'b0, 32'h4, 32'h0);
    chk(v, 32'h13);
    u_far.wr(d[0], 1'b0, 1'b0);
    u_far.wr(d[1], 1'b0, 1'b1);
    u_far.rd(1'b1, 1'b1);
    chk(32'(flags), 32'hB);
    u_far.rd(1'b0, 1'b0);
    chk(32'(rdata), 32'(d[1]));
    @(posedge mclk_i);
    results();
  end
endmodule
`default_nettype wire
